// File: rtl/dcd_pkg.sv
// shared constants and types of the command decoder
// assumes a single 100 MHz core clock samples every pin but reset_n, which acts asynchronously
package dcd_pkg;
  // address field widths for this density and organisation
  localparam int BANK_W = 3;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int ADDR_W = 13;
  localparam int MR_COUNT = 4;
  // address bit roles
  localparam int AP_BIT = 10;
  localparam int CHOP_BIT = 12;
  localparam int MRSEL_HI = 2;
  // burst mode field of mode register 0
  localparam int BL_LSB = 0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [ADDR_W-1:0] MR_RESET = 13'h0000;
  // burst length in rising link clock edges
  localparam logic [2:0] BURST8_CK = 3'h4;
  localparam logic [2:0] BURST4_CK = 3'h2;
  // strobe codes {row, column, write}
  localparam logic [2:0] STB_MODE = 3'h0;
  localparam logic [2:0] STB_REFRESH = 3'h1;
  localparam logic [2:0] STB_PRECHARGE = 3'h2;
  localparam logic [2:0] STB_ACTIVATE = 3'h3;
  localparam logic [2:0] STB_WRITE = 3'h4;
  localparam logic [2:0] STB_READ = 3'h5;
  localparam logic [2:0] STB_ZQ = 3'h6;
  localparam logic [2:0] STB_NOP = 3'h7;

  typedef enum logic [4:0] {
    OP_MODE_SET, OP_REFRESH, OP_SREF_ENTER, OP_SREF_EXIT, OP_PRECHARGE,
    OP_PRECHARGE_ALL, OP_ACTIVATE, OP_WRITE, OP_READ, OP_NOP, OP_DESELECT,
    OP_PDOWN_ENTER, OP_PDOWN_EXIT, OP_ZQ_LONG, OP_ZQ_SHORT, OP_LOW_HOLD, OP_ILLEGAL
  } dcd_op_t;

  typedef enum logic [1:0] {ST_NORMAL, ST_PDOWN, ST_SREF} dcd_state_t;

  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } dcd_pins_t;

  typedef struct packed {
    logic cke_prev;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } dcd_sample_t;
endpackage : dcd_pkg

// File: rtl/dcd_cmd_if.sv
// carrier from the pin sampler to the decoder
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface dcd_cmd_if;
  logic valid;
  dcd_pkg::dcd_sample_t smp;
  logic cke_level;
  modport src (output valid, output smp, output cke_level);
  modport dst (input valid, input smp, input cke_level);
endinterface : dcd_cmd_if

// File: rtl/dcd_slice.sv
// pin synchroniser and link clock edge sampler
// assumes pins are asynchronous to clk and the link clock is much slower
`timescale 1ns/1ps
module dcd_slice (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command pins
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [dcd_pkg::BANK_W-1:0] ba,
  input wire logic [dcd_pkg::ADDR_W-1:0] addr,
  // sampled commands
  dcd_cmd_if.src link
);
  typedef struct packed {
    dcd_pkg::dcd_pins_t meta;
    dcd_pkg::dcd_pins_t sync;
    logic ck_d;
    logic cke_prev;
    logic cke_lvl;
    logic valid;
    dcd_pkg::dcd_sample_t smp;
  } dcd_slice_st_t;

  dcd_slice_st_t q;
  dcd_slice_st_t next_q;
  dcd_pkg::dcd_pins_t pins;

  assign pins = '{ck: ck, cke: cke, cs_n: cs_n, ras_n: ras_n, cas_n: cas_n,
                  we_n: we_n, ba: ba, addr: addr};

  always_comb begin
    next_q = q;
    next_q.meta = pins;
    next_q.sync = q.meta;
    next_q.ck_d = q.sync.ck;
    next_q.cke_lvl = q.sync.cke;
    next_q.valid = q.sync.ck & ~q.ck_d;
    // levels taken only at the rising link clock edge
    if (q.sync.ck && !q.ck_d) begin
      next_q.smp = '{cke_prev: q.cke_prev, cke: q.sync.cke, cs_n: q.sync.cs_n,
                     ras_n: q.sync.ras_n, cas_n: q.sync.cas_n, we_n: q.sync.we_n,
                     ba: q.sync.ba, addr: q.sync.addr};
      next_q.cke_prev = q.sync.cke;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign link.valid = q.valid;
  assign link.smp = q.smp;
  assign link.cke_level = q.cke_lvl;
endmodule : dcd_slice

// File: rtl/dcd_top.sv
// command decoder of the memory device
// assumes the controller drives all pins; clk is a free running 100 MHz clock
//
// Summary of operation
// - commands come from strobe and clock-enable levels at rising link edges, except self refresh exit
// - bank, row and column widths follow this density and organisation
// - low reset pin resets the device at once, independent of any clock
// - bank lines pick the target bank, or the mode register on a mode set
// - write with fixed burst: bit 10 low, bit 12 ignored, low bits column
// - on-the-fly writes chop to four beats with bit 12 low, eight when high
// - write with bit 10 high closes the bank after the burst
// - read matches write encoding with write-enable high, same column field
// - reads use bit 12 as chop select and bit 10 as auto-precharge
// - bursts always finish; fixed or per-command length comes from mode register
// - power-down runs no refresh; the controller keeps refresh duty
// - termination input never steers decoding and is off in self refresh
// - self refresh exit is seen without waiting for a link clock edge
// - no-operation leaves a running burst untouched
// - chip select high is deselect, all else ignored, same as no-operation
`timescale 1ns/1ps
module dcd_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // memory pins
  input wire logic ck,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [dcd_pkg::BANK_W-1:0] ba,
  input wire logic [dcd_pkg::ADDR_W-1:0] addr,
  input wire logic odt,
  // decoded command
  output logic cmd_valid,
  output dcd_pkg::dcd_op_t cmd_op,
  output logic [dcd_pkg::BANK_W-1:0] cmd_bank,
  output logic [dcd_pkg::ROW_W-1:0] cmd_row,
  output logic [dcd_pkg::COL_W-1:0] cmd_col,
  output logic cmd_auto_pre,
  output logic cmd_chop,
  // device state
  output logic burst_busy,
  output logic burst_write,
  output logic [dcd_pkg::BANK_W-1:0] burst_bank,
  output logic power_down,
  output logic self_refresh,
  output logic term_en
);
  typedef struct packed {
    dcd_pkg::dcd_state_t st;
    logic [dcd_pkg::MR_COUNT-1:0][dcd_pkg::ADDR_W-1:0] mr;
    logic [2:0] burst_cnt;
    logic burst_write;
    logic [dcd_pkg::BANK_W-1:0] burst_bank;
    logic odt_meta;
    logic odt_sync;
    logic term_en;
    logic cmd_valid;
    dcd_pkg::dcd_op_t cmd_op;
    logic [dcd_pkg::BANK_W-1:0] cmd_bank;
    logic [dcd_pkg::ROW_W-1:0] cmd_row;
    logic [dcd_pkg::COL_W-1:0] cmd_col;
    logic cmd_auto_pre;
    logic cmd_chop;
  } dcd_top_st_t;

  dcd_top_st_t q;
  dcd_top_st_t next_q;
  logic [1:0] rel;
  logic core_rst;
  dcd_pkg::dcd_op_t op;
  logic chop;
  logic [1:0] bl_mode;

  dcd_cmd_if link ();

  // reset pin acts asynchronously, release is synchronised
  always_ff @(posedge clk or posedge rst or negedge reset_n) begin
    if (rst || !reset_n) begin
      rel <= 2'h0;
    end else begin
      rel <= {rel[0], 1'b1};
    end
  end
  assign core_rst = rst | ~rel[1];

  dcd_slice u_slice (
    .clk(clk),
    .rst(core_rst),
    .ck(ck),
    .cke(cke),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .ba(ba),
    .addr(addr),
    .link(link.src)
  );

  function automatic dcd_pkg::dcd_op_t decode_op(input dcd_pkg::dcd_sample_t s);
    logic [2:0] stb;
    logic idle;
    stb = {s.ras_n, s.cas_n, s.we_n};
    idle = s.cs_n | (stb == dcd_pkg::STB_NOP);
    decode_op = dcd_pkg::OP_ILLEGAL;
    if (s.cke_prev && s.cke) begin
      if (s.cs_n) begin
        decode_op = dcd_pkg::OP_DESELECT;
      end else begin
        case (stb)
          dcd_pkg::STB_MODE: decode_op = dcd_pkg::OP_MODE_SET;
          dcd_pkg::STB_REFRESH: decode_op = dcd_pkg::OP_REFRESH;
          dcd_pkg::STB_PRECHARGE: decode_op = s.addr[dcd_pkg::AP_BIT] ?
            dcd_pkg::OP_PRECHARGE_ALL : dcd_pkg::OP_PRECHARGE;
          dcd_pkg::STB_ACTIVATE: decode_op = dcd_pkg::OP_ACTIVATE;
          dcd_pkg::STB_WRITE: decode_op = dcd_pkg::OP_WRITE;
          dcd_pkg::STB_READ: decode_op = dcd_pkg::OP_READ;
          dcd_pkg::STB_ZQ: decode_op = s.addr[dcd_pkg::AP_BIT] ?
            dcd_pkg::OP_ZQ_LONG : dcd_pkg::OP_ZQ_SHORT;
          default: decode_op = dcd_pkg::OP_NOP;
        endcase
      end
    end else if (s.cke_prev) begin
      // clock enable falling
      if (idle) begin
        decode_op = dcd_pkg::OP_PDOWN_ENTER;
      end else if (stb == dcd_pkg::STB_REFRESH) begin
        decode_op = dcd_pkg::OP_SREF_ENTER;
      end
    end else if (s.cke) begin
      if (idle) begin
        decode_op = dcd_pkg::OP_PDOWN_EXIT;
      end
    end else begin
      decode_op = dcd_pkg::OP_LOW_HOLD;
    end
  endfunction : decode_op

  always_comb begin
    next_q = q;
    op = decode_op(link.smp);
    bl_mode = q.mr[0][dcd_pkg::BL_LSB +: 2];
    // fixed modes ignore bit 12, on-the-fly chops when it is low
    chop = (bl_mode == dcd_pkg::BL_OTF) ? ~link.smp.addr[dcd_pkg::CHOP_BIT] :
           (bl_mode == dcd_pkg::BL_FIXED4);
    next_q.odt_meta = odt;
    next_q.odt_sync = q.odt_meta;
    next_q.cmd_valid = 1'b0;
    if (q.st == dcd_pkg::ST_SREF) begin
      // exit on the synchronised enable level, no link edge needed
      if (link.cke_level) begin
        next_q.st = dcd_pkg::ST_NORMAL;
        next_q.cmd_valid = 1'b1;
        next_q.cmd_op = dcd_pkg::OP_SREF_EXIT;
      end
    end else if (link.valid) begin
      // a running burst counts down whatever arrives
      if (q.burst_cnt != 3'h0) begin
        next_q.burst_cnt = q.burst_cnt - 3'h1;
      end
      if (q.st == dcd_pkg::ST_PDOWN) begin
        // nothing but exit is acted on, no refresh runs here
        if (op == dcd_pkg::OP_PDOWN_EXIT) begin
          next_q.st = dcd_pkg::ST_NORMAL;
          next_q.cmd_valid = 1'b1;
          next_q.cmd_op = op;
        end
      end else if (link.smp.cke_prev) begin
        next_q.cmd_valid = 1'b1;
        next_q.cmd_op = op;
        next_q.cmd_bank = link.smp.ba;
        next_q.cmd_row = link.smp.addr[dcd_pkg::ROW_W-1:0];
        next_q.cmd_col = link.smp.addr[dcd_pkg::COL_W-1:0];
        next_q.cmd_auto_pre = link.smp.addr[dcd_pkg::AP_BIT];
        next_q.cmd_chop = chop;
        case (op)
          dcd_pkg::OP_PDOWN_ENTER: next_q.st = dcd_pkg::ST_PDOWN;
          dcd_pkg::OP_SREF_ENTER: next_q.st = dcd_pkg::ST_SREF;
          dcd_pkg::OP_MODE_SET: begin
            // bank lines select the mode register
            if (!link.smp.ba[dcd_pkg::MRSEL_HI]) begin
              next_q.mr[link.smp.ba[1:0]] = link.smp.addr;
            end
          end
          dcd_pkg::OP_READ, dcd_pkg::OP_WRITE: begin
            // a new burst starts only as the current one ends
            if (q.burst_cnt <= 3'h1) begin
              next_q.burst_cnt = chop ? dcd_pkg::BURST4_CK : dcd_pkg::BURST8_CK;
              next_q.burst_write = (op == dcd_pkg::OP_WRITE);
              next_q.burst_bank = link.smp.ba;
            end
          end
          default: ;
        endcase
      end
    end
    // termination follows its pin only outside self refresh
    next_q.term_en = q.odt_sync & (next_q.st != dcd_pkg::ST_SREF);
  end

  always_ff @(posedge clk or posedge core_rst) begin
    if (core_rst) begin
      q <= '0;
      q.st <= dcd_pkg::ST_NORMAL;
      q.mr <= {dcd_pkg::MR_COUNT{dcd_pkg::MR_RESET}};
      q.cmd_op <= dcd_pkg::OP_DESELECT;
    end else begin
      q <= next_q;
    end
  end

  assign cmd_valid = q.cmd_valid;
  assign cmd_op = q.cmd_op;
  assign cmd_bank = q.cmd_bank;
  assign cmd_row = q.cmd_row;
  assign cmd_col = q.cmd_col;
  assign cmd_auto_pre = q.cmd_auto_pre;
  assign cmd_chop = q.cmd_chop;
  assign burst_busy = (q.burst_cnt != 3'h0);
  assign burst_write = q.burst_write;
  assign burst_bank = q.burst_bank;
  assign power_down = (q.st == dcd_pkg::ST_PDOWN);
  assign self_refresh = (q.st == dcd_pkg::ST_SREF);
  assign term_en = q.term_en;
endmodule : dcd_top

// File: test/dcd_checker.sv
// port assertions and covers for the command decoder top
// assumes clk is the free running core clock and rst its reset
`timescale 1ns/1ps
module dcd_checker (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,
  // decoded command
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_op,
  input wire logic [dcd_pkg::BANK_W-1:0] cmd_bank,
  // device state
  input wire logic burst_busy,
  input wire logic burst_write,
  input wire logic [dcd_pkg::BANK_W-1:0] burst_bank,
  input wire logic power_down,
  input wire logic self_refresh,
  input wire logic term_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  valid_one_clk_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("valid held too long");
  op_hold_a: assert property (reset_n && $past(reset_n) && !cmd_valid |-> $stable(cmd_op))
    else $error("op changed without valid");
  dev_reset_a: assert property (!reset_n |-> !cmd_valid && !burst_busy && !power_down
    && !self_refresh && !term_en) else $error("outputs active in reset");
  burst_start_a: assert property ($rose(burst_busy) |-> cmd_valid
    && cmd_op inside {dcd_pkg::OP_WRITE, dcd_pkg::OP_READ}) else $error("burst without rw");
  burst_target_a: assert property ($rose(burst_busy) |-> burst_bank == cmd_bank
    && burst_write == (cmd_op == dcd_pkg::OP_WRITE)) else $error("burst bank or kind");
  burst_min_a: assert property ($rose(burst_busy) |-> burst_busy [*8])
    else $error("burst cut short");
  pd_silent_a: assert property (power_down && cmd_valid |-> cmd_op inside
    {dcd_pkg::OP_PDOWN_ENTER, dcd_pkg::OP_PDOWN_EXIT, dcd_pkg::OP_LOW_HOLD})
    else $error("command in power-down");
  sref_term_a: assert property (self_refresh && $past(self_refresh) |-> !term_en)
    else $error("termination in self refresh");
  sref_quiet_a: assert property (self_refresh && $past(self_refresh) && cmd_valid
    |-> cmd_op == dcd_pkg::OP_SREF_EXIT) else $error("command in self refresh");
  pd_entry_a: assert property (cmd_valid && cmd_op == dcd_pkg::OP_PDOWN_ENTER
    |-> power_down) else $error("power-down not entered");
  cover property (cmd_valid && cmd_op == dcd_pkg::OP_WRITE);
  cover property (cmd_valid && cmd_op == dcd_pkg::OP_SREF_EXIT);
  cover property (cmd_valid && cmd_op == dcd_pkg::OP_PDOWN_EXIT);
  cover property ($rose(burst_busy) && !burst_write);
endmodule : dcd_checker

bind dcd_top dcd_checker chk (.clk(clk), .rst(rst), .reset_n(reset_n), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_bank(cmd_bank), .burst_busy(burst_busy), .burst_write(burst_write),
  .burst_bank(burst_bank), .power_down(power_down), .self_refresh(self_refresh),
  .term_en(term_en));

// File: test/dcd_ctrl_model.sv
// controller model driving the link clock and command pins
// assumes clk is the 100 MHz core clock, used only for pacing
`timescale 1ns/1ps
module dcd_ctrl_model (
  // pacing clock
  input wire logic clk,
  // command pins
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [dcd_pkg::BANK_W-1:0] ba,
  output logic [dcd_pkg::ADDR_W-1:0] addr,
  output logic odt
);
  initial {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt} = '0;
  // one command per 160 ns link period, pins steady 80 ns each side of the edge
  task automatic send(input logic k, input logic [3:0] c, input logic [2:0] b,
      input logic [12:0] a, input logic o);
    @(posedge clk) #1;
    cke = k;
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = c[3] ? ~ba : b; // deselected lines float, shown toggling
    addr = c[3] ? ~addr : a;
    odt = o;
    repeat (8) @(posedge clk);
    #1 ck = 1;
    repeat (7) @(posedge clk);
    #1 ck = 0;
  endtask : send
  task automatic set_cke(input logic k);
    @(posedge clk) #1 cke = k;
  endtask : set_cke
endmodule : dcd_ctrl_model

// File: test/ddr3_command_decoder_test.sv
// self-checking bench for the command decoder
// assumes the controller model paces all pins but reset_n from the core clock
`timescale 1ns/1ps
module ddr3_command_decoder_test;
  logic clk = 0;
  logic rst = 1;
  logic reset_n = 0;
  logic ck, cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [2:0] ba;
  logic [12:0] addr;
  logic cmd_valid, cmd_auto_pre, cmd_chop, burst_busy, burst_write, power_down;
  logic self_refresh, term_en;
  dcd_pkg::dcd_op_t cmd_op;
  logic [2:0] cmd_bank, burst_bank;
  logic [12:0] cmd_row;
  logic [9:0] cmd_col;
  int num_errors = 0;
  int check_count = 0;
  logic [15:0] lf = 16'h003e;
  logic [1:0] mr0 = 2'h0;
  logic prev = 1;
  int cnt = 0;
  int st = 0;
  logic [3:0] bwb = 4'h0;
  dcd_pkg::dcd_op_t seen[$];
  logic [27:0] fld[$];
  always #5 clk = ~clk;
  dcd_ctrl_model ctl (.clk(clk), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt));
  dcd_top uut (.clk(clk), .rst(rst), .ck(ck), .reset_n(reset_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_row(cmd_row),
    .cmd_col(cmd_col), .cmd_auto_pre(cmd_auto_pre), .cmd_chop(cmd_chop),
    .burst_busy(burst_busy), .burst_write(burst_write), .burst_bank(burst_bank),
    .power_down(power_down), .self_refresh(self_refresh), .term_en(term_en));
  always @(negedge clk) begin
    if (cmd_valid === 1'b1) begin
      seen.push_back(cmd_op);
      fld.push_back({cmd_bank, cmd_col, cmd_auto_pre, cmd_chop, cmd_row});
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // one link command against the reference model
  task automatic cmd(input logic k, input logic [3:0] c, input logic [2:0] b,
      input logic [12:0] a);
    dcd_pkg::dcd_op_t e;
    logic rep;
    logic o;
    logic ch;
    lf = lfsr(lf);
    o = lf[0];
    seen.delete();
    fld.delete();
    ctl.send(k, c, b, a, o);
    rep = 1;
    e = dcd_pkg::OP_PDOWN_EXIT;
    ch = (mr0 == 2'h1) ? ~a[12] : (mr0 == 2'h2);
    if (st == 1) begin
      rep = !prev && k && (c[3] || c[2:0] == dcd_pkg::STB_NOP);
      if (rep) st = 0;
    end else if (st == 2 || !prev) rep = 0;
    else if (!k) begin
      e = (!c[3] && c[2:0] == dcd_pkg::STB_REFRESH) ? dcd_pkg::OP_SREF_ENTER
        : dcd_pkg::OP_PDOWN_ENTER;
      st = (e == dcd_pkg::OP_SREF_ENTER) ? 2 : 1;
    end else if (c[3]) e = dcd_pkg::OP_DESELECT;
    else case (c[2:0])
      dcd_pkg::STB_MODE: e = dcd_pkg::OP_MODE_SET;
      dcd_pkg::STB_REFRESH: e = dcd_pkg::OP_REFRESH;
      dcd_pkg::STB_PRECHARGE: e = a[10] ? dcd_pkg::OP_PRECHARGE_ALL : dcd_pkg::OP_PRECHARGE;
      dcd_pkg::STB_ACTIVATE: e = dcd_pkg::OP_ACTIVATE;
      dcd_pkg::STB_WRITE: e = dcd_pkg::OP_WRITE;
      dcd_pkg::STB_READ: e = dcd_pkg::OP_READ;
      dcd_pkg::STB_ZQ: e = a[10] ? dcd_pkg::OP_ZQ_LONG : dcd_pkg::OP_ZQ_SHORT;
      default: e = dcd_pkg::OP_NOP;
    endcase
    if (e == dcd_pkg::OP_MODE_SET && b == 3'h0) mr0 = a[1:0];
    if (rep && (e == dcd_pkg::OP_WRITE || e == dcd_pkg::OP_READ) && cnt <= 1) begin
      cnt = ch ? 2 : 4;
      bwb = {e == dcd_pkg::OP_WRITE, b};
    end else if (cnt > 0) begin
      cnt--;
    end
    prev = k;
    check(seen.size(), rep);
    if (rep && seen.size() > 0) begin
      check(seen[0], e);
      if (e == dcd_pkg::OP_WRITE || e == dcd_pkg::OP_READ)
        check(fld[0][27:13], {b, a[9:0], a[10], ch});
      if (e == dcd_pkg::OP_ACTIVATE) check({fld[0][27:25], fld[0][12:0]}, {b, a});
    end
    check(burst_busy, cnt > 0);
    check({burst_write, burst_bank}, bwb);
    check({term_en, power_down, self_refresh}, {o && st != 2, st == 1, st == 2});
  endtask : cmd
  initial begin
    #500000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    reset_n = 1;
    ctl.send(1, 4'h7, 3'h0, 13'h0000, 1'b0);
    for (int m = 0; m < 3; m++) begin
      cmd(1, 4'h0, 3'h0, (m == 0) ? 13'h0001 : (m == 1) ? 13'h0002 : 13'h0000);
      for (int s = 0; s < 16; s++) begin
        lf = lfsr(lf);
        cmd(1, {1'b0, s[2:0]}, lf[2:0], lf[15:3]);
      end
      repeat (4) cmd(1, 4'h7, 3'h0, 13'h0000);
      cmd(1, 4'h8, 3'h0, 13'h0000);
    end
    cmd(0, 4'h7, 3'h0, 13'h0000);
    cmd(0, 4'h5, 3'h0, 13'h0000);
    cmd(1, 4'h5, 3'h0, 13'h0000);
    cmd(0, 4'h7, 3'h0, 13'h0000);
    cmd(1, 4'h8, 3'h0, 13'h0000);
    cmd(1, 4'h7, 3'h0, 13'h0000);
    cmd(0, 4'h1, 3'h0, 13'h0000);
    cmd(0, 4'h8, 3'h0, 13'h0000);
    seen.delete();
    ctl.set_cke(1);
    repeat (12) @(posedge clk);
    check(seen.size(), 1);
    if (seen.size() > 0) check(seen[0], dcd_pkg::OP_SREF_EXIT);
    st = 0;
    check(self_refresh, 0);
    repeat (512 * 16) @(posedge clk);
    ctl.send(1, 4'h7, 3'h0, 13'h0000, 1'b0);
    prev = 1;
    cmd(1, 4'h4, 3'h5, 13'h1403);
    repeat (4) cmd(1, 4'h7, 3'h0, 13'h0000);
    @(posedge clk) #1 reset_n = 0;
    repeat (4) @(posedge clk);
    #1 reset_n = 1;
    mr0 = 2'h0;
    cnt = 0;
    ctl.send(1, 4'h7, 3'h0, 13'h0000, 1'b0);
    cmd(1, 4'h5, 3'h2, 13'h0007);
    finish_test();
  end
endmodule : ddr3_command_decoder_test
